// ---- hdl/mbc_params.svh ----
/*
  Register indices, field positions, reset values, mode codes and timing
  counts of the multiplexed bus control block.
  Assumes it is included by bare name from the block's design file.
*/
`ifndef MBC_PARAMS_SVH
`define MBC_PARAMS_SVH
`define MBC_IX_PA 6'h00
`define MBC_IX_PB 6'h01
`define MBC_IX_DA 6'h02
`define MBC_IX_DB 6'h03
`define MBC_IX_PE 6'h08
`define MBC_IX_DE 6'h09
`define MBC_IX_PASN 6'h0A
`define MBC_IX_MODE 6'h0B
`define MBC_IX_PULL 6'h0C
`define MBC_IX_RDRV 6'h0D
`define MBC_IX_EBIC 6'h0E
`define MBC_IX_IRQC 6'h1E
`define MBC_IX_PK 6'h32
`define MBC_IX_DK 6'h33
`define MBC_IX_IST 6'h3C
`define MBC_IX_ICLR 6'h3D
`define MBC_IX_IEN 6'h3E
`define MBC_PASN_NOCLK 4
`define MBC_PASN_LSEN 3
`define MBC_PASN_RWEN 2
`define MBC_MODE_C 7
`define MBC_MODE_A 5
`define MBC_MODE_VIS 3
`define MBC_EBIC_STR 0
`define MBC_IRQC_EDGE 7
`define MBC_IRQC_EN 6
`define MBC_EV_IRQ 0
`define MBC_EV_NMI 1
`define MBC_EV_TAG 2
`define MBC_NEV 3
`define MBC_MD_PERIPH 3'h2
`define MBC_MD_EXPW 3'h5
`define MBC_MD_EMUN 3'h1
`define MBC_BASE_DEF 8'h00
`define MBC_STRETCH_NS 50
`define MBC_CLK_MHZ 40
`endif

// ---- hdl/mbc_pkg.sv ----
/*
  Types shared by the multiplexed bus control block.
  Assumes nothing of its surroundings.
*/
package mbc_pkg;
  typedef enum logic [1:0] {BcIdle, BcLow, BcHigh} mbc_bc_state_t;
endpackage

// ---- hdl/mbc_bus_ctrl.sv ----
/*
  Multiplexed external bus control: bus clock, strobes, direction pin,
  interrupt pins, general ports and their register file on Wishbone.
  Assumes a classic Wishbone master on sys_clk and pins that are
  asynchronous to sys_clk; the core signals accesses on sys_clk.
*/
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
`include "mbc_params.svh"
// Function
// - Bus clock runs free at half the clock rate or pulses low-high per access.
// - In pulse mode a slow access gets a lengthened high phase.
// - Clock-off, visibility and stretch bits choose the bus clock behaviour.
// - Low-byte strobe goes low while low data byte is valid.
// - Peripheral mode: size pin low means 16-bit, high means 8-bit.
// - Tag-low pin low at falling bus clock tags low instruction half.
// - Direction pin is output except in peripheral mode, where it is input.
// - Port E bit 1 is input only and stays readable with interrupt on.
// - Maskable interrupt input supports level and edge detection.
// - Port A/B data and direction registers sit at offsets 0 to 3.
// - Port E, assign, mode, pull, drive, control sit at 8 to 0x0E.
// - Interrupt control at 0x1E, port K data/direction at 0x32/0x33.
// - Register block base is relocatable; upper address bits compared.
// - Mode pins are captured into mode bits as reset releases.
// - Port reads give pin level for inputs, register bit for outputs.
// - Reserved locations and bits read zero; writes to them are ignored.
module mbc_bus_ctrl import mbc_pkg::*; #(
  parameter int STRETCH_CYC =
    (`MBC_STRETCH_NS * `MBC_CLK_MHZ + 999) / 1000
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [15:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] regBase,
  input wire logic accessStart,
  input wire logic accessInternal,
  input wire logic accessSlow,
  input wire logic accessLowByte,
  input wire logic accessWrite,
  input wire logic tagEnable,
  input wire logic irqAck,
  input wire logic [2:0] modeSelPins,
  input wire logic extBusClk,
  input wire logic [7:0] paIn,
  output logic [7:0] paOut,
  output logic [7:0] paOe,
  input wire logic [7:0] pbIn,
  output logic [7:0] pbOut,
  output logic [7:0] pbOe,
  input wire logic [7:0] peIn,
  output logic [7:0] peOut,
  output logic [7:0] peOe,
  input wire logic [7:0] pkIn,
  output logic [7:0] pkOut,
  output logic [7:0] pkOe,
  output logic [7:0] pullCtrl,
  output logic [7:0] driveReduce,
  output logic [2:0] opMode,
  output logic transferSize8,
  output logic periphWrite,
  output logic periphStrobe,
  output logic tagLowHalf,
  output logic maskableReq,
  output logic nonmaskableReq,
  output logic irqOut
);

  // Two-stage synchroniser over every asynchronous pin input.
  localparam int SW = 36;
  logic [SW-1:0] syncA_q;
  logic [SW-1:0] syncB_q;
  wire [SW-1:0] pinRaw = {extBusClk, modeSelPins[0], paIn, pbIn, peIn,
                          pkIn, modeSelPins[2:1]};
  always_ff @(posedge sys_clk) begin
    syncA_q <= pinRaw;
    syncB_q <= syncA_q;
  end
  wire linkClkS = syncB_q[35];
  wire [7:0] paS = syncB_q[33:26];
  wire [7:0] pbS = syncB_q[25:18];
  wire [7:0] peS = syncB_q[17:10];
  wire [7:0] pkS = syncB_q[9:2];
  wire [2:0] modeS = {syncB_q[1:0], syncB_q[34]};

  // Registers written by software, then the strap flag and Wishbone answer flops.
  logic [7:0] pa_q, pb_q, da_q, db_q, pe_q, de_q, pasn_q, mode_q;
  logic [7:0] pull_q, rdrv_q, ebic_q, irqc_q, pk_q, dk_q;
  logic [`MBC_NEV-1:0] ist_q, ien_q;
  logic strapDone_q;
  logic ack_q;
  logic [31:0] rdat_q;

  // Address decode: the upper byte must match the relocated base.
  wire hit = wb_adr_i[15:8] == regBase;
  wire [5:0] idx = wb_adr_i[7:2];
  wire req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr = req & wb_we_i & wb_sel_i[0] & hit;
  wire [7:0] wd = wb_dat_i[7:0];

  function automatic logic wsel(input logic [5:0] ix, input logic [5:0] t);
    wsel = ix == t;
  endfunction

  // Port read: input pins show the pin, output pins show the latch.
  function automatic logic [7:0] pread(input logic [7:0] d,
                                       input logic [7:0] dir,
                                       input logic [7:0] pin);
    pread = (d & dir) | (pin & ~dir);
  endfunction

  wire [2:0] md = mode_q[`MBC_MODE_C:`MBC_MODE_A];
  wire periph = md == `MBC_MD_PERIPH;
  wire tagMode = md == `MBC_MD_EXPW || md == `MBC_MD_EMUN;
  wire clkOff = pasn_q[`MBC_PASN_NOCLK];
  wire intVis = mode_q[`MBC_MODE_VIS];
  wire stretchEn = ebic_q[`MBC_EBIC_STR];

  // Bits 1 and 0 are input-only and always show the pin level.
  wire [7:0] peMix = pread(pe_q, de_q, peS);
  wire [7:0] peRd = {peMix[7:2], peS[1:0]};

  // Read multiplexer; unmapped indices and reserved bits read zero.
  logic [7:0] rsel;
  always_comb begin
    rsel = 8'h00;
    case (idx)
      `MBC_IX_PA: rsel = pread(pa_q, da_q, paS);
      `MBC_IX_PB: rsel = pread(pb_q, db_q, pbS);
      `MBC_IX_DA: rsel = da_q;
      `MBC_IX_DB: rsel = db_q;
      `MBC_IX_PE: rsel = peRd;
      `MBC_IX_DE: rsel = {de_q[7:2], 2'h0};
      `MBC_IX_PASN: rsel = pasn_q;
      `MBC_IX_MODE: rsel = mode_q;
      `MBC_IX_PULL: rsel = pull_q;
      `MBC_IX_RDRV: rsel = rdrv_q;
      `MBC_IX_EBIC: rsel = ebic_q;
      `MBC_IX_IRQC: rsel = irqc_q;
      `MBC_IX_PK: rsel = pread(pk_q, dk_q, pkS);
      `MBC_IX_DK: rsel = dk_q;
      `MBC_IX_IST: rsel = {5'h00, ist_q};
      `MBC_IX_IEN: rsel = {5'h00, ien_q};
      default: rsel = 8'h00;
    endcase
  end

  // Wishbone answer: ack one cycle after the request, dropped after one.
  // A miss on the base still acks with zero so the master never hangs.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      rdat_q <= {24'h00_0000, hit ? rsel : 8'h00};
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Port data and direction registers.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      {pa_q, pb_q, da_q} <= '0;
      {db_q, pk_q, dk_q} <= '0;
    end else if (wr) begin
      if (wsel(idx, `MBC_IX_PA)) pa_q <= wd;
      if (wsel(idx, `MBC_IX_PB)) pb_q <= wd;
      if (wsel(idx, `MBC_IX_DA)) da_q <= wd;
      if (wsel(idx, `MBC_IX_DB)) db_q <= wd;
      if (wsel(idx, `MBC_IX_PK)) pk_q <= wd;
      if (wsel(idx, `MBC_IX_DK)) dk_q <= wd;
    end
  end

  // Port E and bus control registers; bits 1:0 of port E stay zero.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      {pe_q, de_q, pasn_q, pull_q} <= '0;
      {rdrv_q, ebic_q, irqc_q} <= '0;
    end else if (wr) begin
      if (wsel(idx, `MBC_IX_PE)) pe_q <= {wd[7:2], 2'h0};
      if (wsel(idx, `MBC_IX_DE)) de_q <= {wd[7:2], 2'h0};
      if (wsel(idx, `MBC_IX_PASN)) pasn_q <= wd;
      if (wsel(idx, `MBC_IX_PULL)) pull_q <= wd;
      if (wsel(idx, `MBC_IX_RDRV)) rdrv_q <= wd;
      if (wsel(idx, `MBC_IX_EBIC)) ebic_q <= wd;
      if (wsel(idx, `MBC_IX_IRQC)) irqc_q <= wd;
    end
  end

  // Mode register: the strap is caught in the first cycle after release,
  // never under reset, since reset may only load constants.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      strapDone_q <= 1'b0;
      mode_q <= 8'h00;
    end else if (!strapDone_q) begin
      strapDone_q <= 1'b1;
      mode_q[`MBC_MODE_C:`MBC_MODE_A] <= modeS;
    end else if (wr && wsel(idx, `MBC_IX_MODE)) begin
      mode_q[`MBC_MODE_VIS] <= wd[`MBC_MODE_VIS];
    end
  end

  // Bus clock state machine and access latches.
  mbc_bc_state_t bcState_q, bcState_d;
  logic [7:0] hiCnt_q, hiCnt_d;
  logic bc_q, bc_d;
  logic strobe_q, rw_q;
  wire visible = accessStart & (~accessInternal | intVis);
  wire [7:0] hiLen = (accessSlow & stretchEn) ? 8'(STRETCH_CYC) : 8'h00;

  // Free-running toggles every cycle; otherwise one pulse per visible access, none with clock-off.
  always_comb begin
    bcState_d = bcState_q;
    hiCnt_d = hiCnt_q;
    bc_d = 1'b0;
    case (bcState_q)
      BcIdle: begin
        if (clkOff) begin
          bc_d = 1'b0;
        end else if (!stretchEn) begin
          bc_d = ~bc_q;
        end else if (visible) begin
          bcState_d = BcLow;
          hiCnt_d = hiLen;
        end
      end
      BcLow: begin
        bcState_d = BcHigh;
        bc_d = 1'b1;
      end
      BcHigh: begin
        if (hiCnt_q == 8'h00) begin
          bcState_d = BcIdle;
        end else begin
          hiCnt_d = hiCnt_q - 8'h01;
          bc_d = 1'b1;
        end
      end
      default: bcState_d = BcIdle;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      bcState_q <= BcIdle;
      hiCnt_q <= 8'h00;
      bc_q <= 1'b0;
    end else begin
      bcState_q <= bcState_d;
      hiCnt_q <= hiCnt_d;
      bc_q <= bc_d;
    end
  end

  // Strobe and direction are latched at the access start and held
  // until the pulse ends, so they stay steady across the high phase.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      strobe_q <= 1'b1;
      rw_q <= 1'b1;
    end else if (bcState_q == BcIdle && accessStart) begin
      strobe_q <= ~accessLowByte;
      rw_q <= ~accessWrite;
    end else if (bcState_q == BcIdle && !accessStart) begin
      strobe_q <= 1'b1;
      rw_q <= 1'b1;
    end
  end

  // Port E pin drive: alternate functions take over bits 4 to 2.
  logic [7:0] peOut_d, peOe_d;
  always_comb begin
    peOut_d = pe_q;
    peOe_d = {de_q[7:2], 2'h0};
    if (!clkOff) begin
      peOut_d[4] = bc_q;
      peOe_d[4] = 1'b1;
    end
    if (periph) begin
      peOe_d[3] = 1'b0;
      peOe_d[2] = 1'b0;
    end else begin
      if (pasn_q[`MBC_PASN_LSEN]) begin
        peOut_d[3] = strobe_q;
        peOe_d[3] = 1'b1;
      end
      if (pasn_q[`MBC_PASN_RWEN]) begin
        peOut_d[2] = rw_q;
        peOe_d[2] = 1'b1;
      end
    end
  end

  // Tag sampling at our own falling bus clock edge.
  logic bcOld_q;
  wire bcFall = bcOld_q & ~bc_q;
  wire tagHit = bcFall & tagMode & tagEnable & pasn_q[`MBC_PASN_LSEN] &
                ~peS[3];

  // Tester strobe edges: the synchronised link clock rising edge
  // samples size and direction in peripheral mode.
  logic linkOld_q;
  wire linkRise = linkClkS & ~linkOld_q;

  // Interrupt pins are active low; edge mode looks for a falling level.
  logic irqOld_q, nmiOld_q, irqEdge_q;
  wire irqFall = irqOld_q & ~peS[1];
  wire nmiFall = nmiOld_q & ~peS[0];
  wire irqEdgeMode = irqc_q[`MBC_IRQC_EDGE];
  wire irqEn = irqc_q[`MBC_IRQC_EN];
  wire [`MBC_NEV-1:0] ev = {tagHit, nmiFall, irqFall & irqEn};
  wire clrWr = wr & wsel(idx, `MBC_IX_ICLR);
  wire [`MBC_NEV-1:0] clrBits = clrWr ? wd[`MBC_NEV-1:0] : '0;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      bcOld_q <= 1'b0;
      linkOld_q <= 1'b0;
      irqOld_q <= 1'b1;
      nmiOld_q <= 1'b1;
    end else begin
      bcOld_q <= bc_q;
      linkOld_q <= linkClkS;
      irqOld_q <= peS[1];
      nmiOld_q <= peS[0];
    end
  end

  // Edge latch for the maskable request: set wins over the acknowledge.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      irqEdge_q <= 1'b0;
    end else if (irqFall & irqEn) begin
      irqEdge_q <= 1'b1;
    end else if (irqAck | ~irqEn) begin
      irqEdge_q <= 1'b0;
    end
  end

  // Sticky event status; a new event beats a clear in the same cycle.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ist_q <= '0;
      ien_q <= '0;
    end else begin
      ist_q <= (ist_q & ~clrBits) | ev;
      if (wr && wsel(idx, `MBC_IX_IEN)) ien_q <= wd[`MBC_NEV-1:0];
    end
  end

  // Registered outputs: every port below comes straight off a flop.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      {paOut, paOe, pbOut, pbOe, peOut, peOe} <= '0;
      {pkOut, pkOe, pullCtrl, driveReduce} <= '0;
      {opMode, transferSize8, periphWrite, periphStrobe} <= '0;
      {tagLowHalf, maskableReq, nonmaskableReq, irqOut} <= '0;
    end else begin
      paOut <= pa_q;
      paOe <= da_q;
      pbOut <= pb_q;
      pbOe <= db_q;
      peOut <= peOut_d;
      peOe <= peOe_d;
      pkOut <= pk_q;
      pkOe <= dk_q;
      pullCtrl <= pull_q;
      driveReduce <= rdrv_q;
      opMode <= md;
      periphStrobe <= periph & linkRise;
      if (periph && linkRise) begin
        transferSize8 <= peS[3];
        periphWrite <= ~peS[2];
      end
      tagLowHalf <= tagHit;
      maskableReq <= irqEn & (irqEdgeMode ? irqEdge_q : ~peS[1]);
      nonmaskableReq <= ~peS[0];
      irqOut <= |(ist_q & ien_q);
    end
  end

endmodule

// ---- verif/mbc_bus_ctrl_chk.sv ----
/*
  Port checker of the bus control block.
  Assumes it is bound to mbc_bus_ctrl and sees only its ports.
*/
`timescale 1ns/1ps
`include "mbc_params.svh"
module mbc_bus_ctrl_chk (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [7:0] peIn,
  input wire logic [7:0] peOe,
  input wire logic [2:0] opMode,
  input wire logic periphStrobe,
  input wire logic nonmaskableReq
);
  // One clock domain, so clock and reset are named once.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Every request is answered, mapped or not, in one cycle.
  chk_ack_next: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged");
  chk_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  chk_dat_zero: assert property (
    wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("unused read bits set");
  // Pin to request passes a two-flop synchroniser.
  chk_nmi_raise: assert property (
    $fell(peIn[0]) |-> ##[1:5] nonmaskableReq)
    else $error("nonmaskable request missing");
  chk_nmi_drop: assert property (
    $rose(peIn[0]) |-> ##[1:5] !nonmaskableReq)
    else $error("nonmaskable request stuck");
  chk_pin_input: assert property (
    peOe[1:0] == 2'h0) else $error("input-only pin driven");
  chk_dir_input: assert property (
    opMode == `MBC_MD_PERIPH |-> !peOe[2])
    else $error("direction pin driven in peripheral mode");
  chk_strobe_mode: assert property (
    periphStrobe |-> opMode == `MBC_MD_PERIPH)
    else $error("tester strobe outside peripheral mode");
  // The strap is taken only just after reset.
  chk_strap_hold: assert property (
    $changed(opMode) |-> !$past(resetn, 2) || !$past(resetn, 3))
    else $error("mode changed outside reset");
endmodule

bind mbc_bus_ctrl mbc_bus_ctrl_chk i_chk (.sys_clk, .resetn, .wb_cyc_i,
  .wb_stb_i, .wb_dat_o, .wb_ack_o, .peIn, .peOe, .opMode, .periphStrobe,
  .nonmaskableReq);

// ---- verif/mbc_tester_model.sv ----
/*
  Tester bus master: bus clock, size and direction pins.
  Assumes pulled-up pins, so released pins read high.
*/
`timescale 1ns/1ps
module mbc_tester_model (
  input wire logic frameOn,
  input wire logic want8,
  input wire logic wantWr,
  output logic extBusClk,
  output logic szPin,
  output logic rwPin
);
  // Size and direction are driven only inside a frame.
  assign szPin = frameOn ? want8 : 1'b1;
  assign rwPin = frameOn ? !wantWr : 1'b1;
  // Clock stands low between frames; the offset keeps it off sys_clk.
  initial begin
    extBusClk = 1'b0;
    #7;
    forever #100 extBusClk = frameOn ? !extBusClk : 1'b0;
  end
endmodule

// ---- verif/testbench.sv ----
/*
  Self-checking bench of the bus control block.
  Assumes the block, its checker and the tester model are compiled.
*/
`timescale 1ns/1ps
module testbench;
  localparam int STR = 2;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] wb_adr_i = 16'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [7:0] regBase = 8'h00;
  logic accessStart = 1'b0;
  logic accessInternal = 1'b0;
  logic tagEnable = 1'b0;
  logic accessSlow = 1'b0;
  logic accessLowByte = 1'b0;
  logic accessWrite = 1'b0;
  logic irqAck = 1'b0;
  logic [2:0] modeSelPins = 3'h0;
  logic [7:0] paIn = 8'h00;
  logic [7:0] pbIn = 8'h00;
  logic [7:0] pkIn = 8'h00;
  logic [1:0] peLow = 2'h3;
  logic frameOn = 1'b0;
  logic want8 = 1'b0;
  logic wantWr = 1'b0;
  logic extBusClk, szPin, rwPin, b, miss;
  logic [7:0] peIn, peOut, peOe, pullCtrl, driveReduce, rd, v, w;
  logic [7:0] paOut, paOe, pbOut, pbOe, pkOut, pkOe;
  logic [2:0] opMode;
  logic transferSize8, periphWrite, periphStrobe, maskableReq;
  logic nonmaskableReq, irqOut, tagLowHalf;
  logic [31:0] seed = 32'h8B9D;
  logic [5:0] rsv [5] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h0F};
  int nErrors = 0;
  int compares = 0;
  int n;
  int nTag = 0;
  assign peIn = {4'hF, szPin, rwPin, peLow};
  mbc_bus_ctrl #(.STRETCH_CYC(STR)) i_dut (
    .sys_clk, .resetn, .wb_adr_i, .wb_dat_i, .wb_sel_i(4'h1), .wb_we_i,
    .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .regBase, .accessStart,
    .accessInternal, .accessSlow, .accessLowByte, .accessWrite,
    .tagEnable, .irqAck, .modeSelPins, .extBusClk, .paIn, .paOut,
    .paOe, .pbIn, .pbOut, .pbOe, .peIn, .peOut, .peOe, .pkIn,
    .pkOut, .pkOe, .pullCtrl, .driveReduce, .opMode, .transferSize8,
    .periphWrite, .periphStrobe, .tagLowHalf, .maskableReq,
    .nonmaskableReq, .irqOut);
  mbc_tester_model i_tester (.frameOn, .want8, .wantWr, .extBusClk,
    .szPin, .rwPin);
  // Tag pulses last one cycle, so they are counted as they pass.
  always @(posedge sys_clk) begin
    if (tagLowHalf === 1'b1) nTag <= nTag + 1;
  end
  // Free-running system clock.
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  // Input bits read the pin, output bits read the stored value.
  function automatic logic [7:0] portRd(logic [7:0] d, m, p);
    return (m & d) | (~m & p);
  endfunction
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      nErrors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cmpBit(input logic got, input logic exp);
    cmp({7'h0, got}, {7'h0, exp});
  endtask
  task automatic wrapUp();
    $display("errors %0d, compares %0d", nErrors, compares);
    if (nErrors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  // Classic cycle: request held until ack is sampled, then dropped.
  task automatic wb(input logic we, input logic [5:0] ix,
                    input logic [7:0] wd);
    int k;
    k = 0;
    wb_adr_i <= {regBase ^ {7'h0, miss}, ix, 2'b00};
    wb_we_i <= we;
    wb_dat_i <= {24'h0, wd};
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 16);
    if (wb_ack_o !== 1'b1) begin
      nErrors++;
      wrapUp();
    end
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic doReset(input logic [2:0] m);
    modeSelPins <= m;
    resetn <= 1'b0;
    tick(3);
    resetn <= 1'b1;
    tick(3);
  endtask
  task automatic portChk(input logic [5:0] dx, input logic [5:0] mx,
                         input logic [7:0] p, output logic [7:0] d,
                         output logic [7:0] m);
    d = rnd();
    m = rnd();
    wb(1'b1, dx, d);
    wb(1'b1, mx, m);
    wb(1'b0, dx, 8'h00);
    cmp(rd, portRd(d, m, p));
    wb(1'b0, mx, 8'h00);
    cmp(rd, m);
  endtask
  task automatic setIrq(input logic l);
    peLow[1] <= l;
    tick(6);
  endtask
  // One visible access; the high phase of the bus clock is counted.
  task automatic busAcc(input logic s, input logic lb, input logic w);
    int k;
    k = 0;
    accessStart <= 1'b1;
    accessSlow <= s;
    accessLowByte <= lb;
    accessWrite <= w;
    @(posedge sys_clk);
    accessStart <= 1'b0;
    while (peOut[4] !== 1'b1 && k < 8) begin
      @(posedge sys_clk);
      k++;
    end
    cmpBit(peOut[3], !lb);
    cmpBit(peOut[2], !w);
    k = 0;
    while (peOut[4] === 1'b1 && k < 8) begin
      @(posedge sys_clk);
      k++;
    end
    cmp(8'(k), s ? 8'(1 + STR) : 8'h01);
    tick(2);
  endtask
  // Main sequence: registers, interrupts, bus clock, peripheral mode.
  initial begin
    miss = 1'b0;
    doReset(3'h5);
    cmp({5'h0, opMode}, 8'h05);
    wb(1'b0, 6'h0B, 8'h00);
    cmp(rd & 8'hE0, 8'hA0);
    regBase <= rnd();
    paIn <= rnd();
    pbIn <= rnd();
    pkIn <= rnd();
    tick(1);
    portChk(6'h00, 6'h02, paIn, v, w);
    cmp(paOut, v);
    cmp(paOe, w);
    portChk(6'h01, 6'h03, pbIn, v, w);
    cmp(pbOut, v);
    cmp(pbOe, w);
    portChk(6'h32, 6'h33, pkIn, v, w);
    cmp(pkOut, v);
    cmp(pkOe, w);
    v = rnd();
    wb(1'b1, 6'h0C, v);
    cmp(pullCtrl, v);
    wb(1'b1, 6'h0D, ~v);
    cmp(driveReduce, ~v);
    miss = 1'b1;
    wb(1'b1, 6'h0C, ~v);
    wb(1'b0, 6'h0C, 8'h00);
    cmp(rd, 8'h00);
    miss = 1'b0;
    wb(1'b0, 6'h0C, 8'h00);
    cmp(rd, v);
    foreach (rsv[i]) begin
      wb(1'b1, rsv[i], 8'hFF);
      wb(1'b0, rsv[i], 8'h00);
      cmp(rd, 8'h00);
    end
    wb(1'b1, 6'h1E, 8'hC0);
    setIrq(1'b0);
    wb(1'b0, 6'h08, 8'h00);
    cmp(rd & 8'h03, 8'h01);
    setIrq(1'b1);
    cmpBit(maskableReq, 1'b1);
    irqAck <= 1'b1;
    tick(1);
    irqAck <= 1'b0;
    tick(2);
    cmpBit(maskableReq, 1'b0);
    wb(1'b1, 6'h1E, 8'h40);
    setIrq(1'b0);
    cmpBit(maskableReq, 1'b1);
    setIrq(1'b1);
    cmpBit(maskableReq, 1'b0);
    peLow[0] <= 1'b0;
    tick(6);
    cmpBit(nonmaskableReq, 1'b1);
    cmpBit(irqOut, 1'b0);
    peLow[0] <= 1'b1;
    tick(6);
    wb(1'b0, 6'h3C, 8'h00);
    cmp(rd & 8'h02, 8'h02);
    wb(1'b1, 6'h3E, 8'h02);
    tick(1);
    cmpBit(irqOut, 1'b1);
    wb(1'b1, 6'h3D, 8'h02);
    tick(1);
    cmpBit(irqOut, 1'b0);
    wb(1'b1, 6'h0A, 8'h0C);
    wb(1'b1, 6'h0E, 8'h00);
    b = peOut[4];
    tick(1);
    cmpBit(peOut[4], !b);
    wb(1'b1, 6'h0E, 8'h01);
    busAcc(1'b1, 1'b1, 1'b0);
    repeat (4) begin
      v = rnd();
      busAcc(v[0], v[1], v[2]);
    end
    tagEnable <= 1'b1;
    want8 <= 1'b0;
    frameOn <= 1'b1;
    busAcc(1'b0, 1'b0, 1'b1);
    frameOn <= 1'b0;
    tagEnable <= 1'b0;
    tick(3);
    cmp(8'(nTag), 8'h01);
    wb(1'b0, 6'h3C, 8'h00);
    cmp(rd & 8'h04, 8'h04);
    accessInternal <= 1'b1;
    accessStart <= 1'b1;
    tick(1);
    accessStart <= 1'b0;
    repeat (6) begin
      tick(1);
      cmpBit(peOut[4], 1'b0);
    end
    wb(1'b1, 6'h0B, 8'h08);
    busAcc(1'b0, 1'b1, 1'b0);
    accessInternal <= 1'b0;
    wb(1'b1, 6'h0A, 8'h1C);
    tick(2);
    cmpBit(peOe[4], 1'b0);
    doReset(3'h2);
    cmp({5'h0, opMode}, 8'h02);
    v = rnd();
    want8 <= v[0];
    wantWr <= v[1];
    frameOn <= 1'b1;
    n = 0;
    while (periphStrobe !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    if (periphStrobe !== 1'b1) begin
      nErrors++;
      wrapUp();
    end
    tick(2);
    cmpBit(transferSize8, v[0]);
    cmpBit(periphWrite, v[1]);
    frameOn <= 1'b0;
    tick(2);
    wrapUp();
  end
endmodule
